/* logic/dam_abstract_cmd.sv */
// Abstract register and memory command executor with auto-execute
`timescale 1ns/10ps
`default_nettype none
`include "dam_map.svh"

module dam_abstract_cmd
    import dam_pkg::*;
#(
    parameter logic [31:0] INT_BASE = 32'hF000_0000,
    parameter logic [31:0] ILM_BASE = 32'hF000_0000,
    parameter logic [31:0] DLM_BASE = 32'hF004_0000,
    parameter logic [31:0] IRQ_BASE = 32'hF00C_0000,
    parameter int LOCAL_AW = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic dmi_req,
    input wire logic dmi_wr,
    input wire logic [6:0] dmi_addr,
    input wire logic [31:0] dmi_wdata,
    output logic [31:0] dmi_rdata,
    output logic dmi_ack,
    input wire logic halted,
    output logic cmd_busy,
    output logic [2:0] cmd_err,
    output logic reg_req,
    output logic reg_wr,
    output logic [15:0] reg_num,
    output logic [31:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic [31:0] reg_rdata,
    output logic mem_req,
    output logic mem_wr,
    output logic [31:0] mem_addr,
    output logic [1:0] mem_size,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata
);
    localparam dam_regs_t Q_RST = '{
        st: dam_idle,
        busy: 1'b0,
        cmderr: `DAM_E_NONE,
        cmd: `DAM_CMD_RST,
        dataw: 32'h0000_0000,
        addrw: 32'h0000_0000,
        rdata: 32'h0000_0000,
        auto_ex: `DAM_AUTO_RST,
        ack: 1'b0,
        reg_req: 1'b0,
        mem_req: 1'b0
    };

    dam_regs_t q;
    dam_regs_t n;
    logic start;
    logic [31:0] chk_cmd;
    logic [31:0] chk_addr;
    logic [2:0] chk_err;
    dam_kind_t chk_kind;
    logic [31:0] bump;

    // New command word or new address is checked in its own cycle
    assign chk_cmd = (dmi_req && dmi_wr && dmi_addr == `DAM_A_CMD) ?
        dmi_wdata : q.cmd;
    assign chk_addr = (dmi_req && dmi_wr && dmi_addr == `DAM_A_ADDRW) ?
        dmi_wdata : q.addrw;
    assign bump = 32'h0000_0001 << q.cmd[`DAM_F_SZ +: 2];

    dam_cmd_check #(
        .INT_BASE(INT_BASE),
        .ILM_BASE(ILM_BASE),
        .DLM_BASE(DLM_BASE),
        .IRQ_BASE(IRQ_BASE),
        .LOCAL_AW(LOCAL_AW)
    ) u_check (
        .cmd(chk_cmd),
        .addr(chk_addr),
        .halted(halted),
        .err(chk_err),
        .kind(chk_kind)
    );

    // Register access, command launch and completion
    always_comb begin
        logic busy_hit;
        logic [31:0] cw;
        busy_hit = 1'b0;
        cw = dmi_wdata;
        n = q;
        start = 1'b0;
        n.ack = 1'b0;
        if (dmi_req) begin
            n.ack = 1'b1;
            n.rdata = 32'h0000_0000;
            if (dmi_addr == `DAM_A_DATAW) begin
                n.rdata = q.dataw;
                if (q.busy) begin
                    busy_hit = 1'b1;
                end else begin
                    if (dmi_wr) begin
                        n.dataw = dmi_wdata;
                    end
                    start = q.auto_ex[0] && q.cmderr == `DAM_E_NONE;
                end
            end else if (dmi_addr == `DAM_A_ADDRW) begin
                n.rdata = q.addrw;
                if (q.busy) begin
                    busy_hit = 1'b1;
                end else begin
                    if (dmi_wr) begin
                        n.addrw = dmi_wdata;
                    end
                    start = q.auto_ex[1] && q.cmderr == `DAM_E_NONE;
                end
            end else if (dmi_addr == `DAM_A_CS) begin
                n.rdata[`DAM_F_BUSY] = q.busy;
                n.rdata[`DAM_F_ERR +: 3] = q.cmderr;
                n.rdata[3:0] = `DAM_DATACOUNT;
                if (dmi_wr) begin
                    n.cmderr = q.cmderr & ~dmi_wdata[`DAM_F_ERR +: 3];
                end
            end else if (dmi_addr == `DAM_A_CMD) begin
                if (dmi_wr) begin
                    if (q.busy) begin
                        busy_hit = 1'b1;
                    end else if (q.cmderr == `DAM_E_NONE) begin
                        if (cw[31:24] == `DAM_T_MEM) begin
                            cw[`DAM_F_VIRT] = 1'b0;
                            cw[18:17] = 2'h0;
                            cw[15:0] = 16'h0000;
                        end
                        n.cmd = cw;
                        start = 1'b1;
                    end
                end
            end else if (dmi_addr == `DAM_A_AUTO) begin
                n.rdata = {30'h0000_0000, q.auto_ex};
                if (dmi_wr) begin
                    if (q.busy) begin
                        busy_hit = 1'b1;
                    end else begin
                        n.auto_ex = dmi_wdata[1:0];
                    end
                end
            end
        end
        // Busy collisions set the code only when it was clear
        if (busy_hit && q.cmderr == `DAM_E_NONE) begin
            n.cmderr = `DAM_E_BUSY;
        end
        // Launch or refuse a started command
        if (start) begin
            if (chk_err != `DAM_E_NONE) begin
                n.cmderr = chk_err;
            end else if (chk_kind == dam_k_reg) begin
                n.st = dam_reg;
                n.reg_req = 1'b1;
            end else if (chk_kind == dam_k_mem) begin
                n.st = dam_mem;
                n.mem_req = 1'b1;
            end
        end
        // Completion; error set after the clear so it wins
        case (q.st)
            dam_reg: begin
                if (reg_ack) begin
                    n.reg_req = 1'b0;
                    n.st = dam_idle;
                    if (!q.cmd[`DAM_F_WR]) begin
                        n.dataw = reg_rdata;
                    end
                end
            end
            dam_mem: begin
                if (mem_ack) begin
                    n.mem_req = 1'b0;
                    n.st = dam_idle;
                    if (mem_err) begin
                        n.cmderr = `DAM_E_BUS;
                    end else begin
                        if (!q.cmd[`DAM_F_WR]) begin
                            n.dataw = mem_rdata;
                        end
                        if (q.cmd[`DAM_F_POST]) begin
                            n.addrw = q.addrw + bump;
                        end
                    end
                end
            end
            default: begin
            end
        endcase
        n.busy = n.st != dam_idle;
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= Q_RST;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state flops
    assign dmi_rdata = q.rdata;
    assign dmi_ack = q.ack;
    assign cmd_busy = q.busy;
    assign cmd_err = q.cmderr;
    assign reg_req = q.reg_req;
    assign reg_wr = q.cmd[`DAM_F_WR];
    assign reg_num = q.cmd[15:0];
    assign reg_wdata = q.dataw;
    assign mem_req = q.mem_req;
    assign mem_wr = q.cmd[`DAM_F_WR];
    assign mem_addr = q.addrw;
    assign mem_size = q.cmd[`DAM_F_SZ +: 2];
    assign mem_wdata = q.dataw;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    wire cmd_wr = dmi_req && dmi_wr && dmi_addr == `DAM_A_CMD;

    err_block_a: assert property (
        cmd_wr && !q.busy && q.cmderr != `DAM_E_NONE
        |=> q.st == dam_idle && $stable(q.cmd))
        else $error("command accepted while error set");
    halt_abort_a: assert property (
        cmd_wr && !q.busy && q.cmderr == `DAM_E_NONE && !halted
        |=> q.cmderr == `DAM_E_HALT && !q.busy)
        else $error("command not aborted when running");
    auto_busy_a: assert property (
        dmi_req && dmi_wr && dmi_addr == `DAM_A_AUTO && q.busy &&
        q.cmderr == `DAM_E_NONE |=> q.cmderr == `DAM_E_BUSY)
        else $error("busy error missing");
    addr_bump_a: assert property (
        q.st == dam_mem && mem_ack && !mem_err && q.cmd[`DAM_F_POST]
        |=> q.addrw == $past(q.addrw) + $past(bump))
        else $error("address not bumped by size");
    fail_bump_a: assert property (
        q.st == dam_mem && mem_ack && mem_err
        |=> q.cmderr == `DAM_E_BUS && $stable(q.addrw))
        else $error("failed access bumped or no error");
    read_data_a: assert property (
        q.st == dam_mem && mem_ack && !mem_err && !q.cmd[`DAM_F_WR]
        |=> q.dataw == $past(mem_rdata))
        else $error("read data not captured");
    regno_bad_a: assert property (
        cmd_wr && !q.busy && q.cmderr == `DAM_E_NONE && halted &&
        dmi_wdata[31:24] == `DAM_T_REG && dmi_wdata[`DAM_F_XFER] &&
        dmi_wdata[`DAM_F_SZ +: 3] == `DAM_SZ_WORD &&
        !dmi_wdata[`DAM_F_PEXEC] && dmi_wdata[15:0] > `DAM_GPR_LAST
        |=> q.cmderr == `DAM_E_EXC && !reg_req)
        else $error("bad register number not refused");
    addr_rerun_a: assert property (
        dmi_req && dmi_addr == `DAM_A_ADDRW && !q.busy && q.auto_ex[1] &&
        q.cmderr == `DAM_E_NONE && chk_kind == dam_k_mem &&
        chk_err == `DAM_E_NONE |=> mem_req ##0 $rose(q.busy))
        else $error("address access did not rerun");
    size_bad_a: assert property (
        start && halted && chk_cmd[31:24] == `DAM_T_MEM &&
        chk_cmd[`DAM_F_SZ +: 3] > `DAM_SZ_WORD
        |=> q.cmderr == `DAM_E_CMD && !mem_req)
        else $error("bad size not refused");

    mem_done_c: cover property (q.st == dam_mem && mem_ack && !mem_err);
    reg_done_c: cover property (q.st == dam_reg && reg_ack);
    auto_run_c: cover property (start && q.auto_ex != 2'h0 ##1 q.busy);
endmodule // dam_abstract_cmd
`default_nettype wire

/* logic/dam_map.svh */
// Offsets, field positions, codes and reset values of the command block
`ifndef DAM_MAP_SVH
`define DAM_MAP_SVH
// Register offsets on the debug module interface
`define DAM_A_DATAW 7'h04
`define DAM_A_ADDRW 7'h05
`define DAM_A_CS 7'h16
`define DAM_A_CMD 7'h17
`define DAM_A_AUTO 7'h18
// Command word field positions
`define DAM_F_TYPE 24
`define DAM_F_VIRT 23
`define DAM_F_SZ 20
`define DAM_F_POST 19
`define DAM_F_PEXEC 18
`define DAM_F_XFER 17
`define DAM_F_WR 16
// Status word field positions
`define DAM_F_BUSY 12
`define DAM_F_ERR 8
`define DAM_DATACOUNT 4'h2
// Command kinds, sizes and register number limits
`define DAM_T_REG 8'h00
`define DAM_T_MEM 8'h02
`define DAM_SZ_WORD 3'h2
`define DAM_GPR_LAST 16'h101F
// Error codes
`define DAM_E_NONE 3'h0
`define DAM_E_BUSY 3'h1
`define DAM_E_CMD 3'h2
`define DAM_E_EXC 3'h3
`define DAM_E_HALT 3'h4
`define DAM_E_BUS 3'h5
// Reset values
`define DAM_CMD_RST 32'h0022_0000
`define DAM_AUTO_RST 2'h0
`endif

/* logic/dam_pkg.sv */
// Types shared by the command block files
package dam_pkg;
    typedef enum logic [1:0] {dam_idle, dam_reg, dam_mem} dam_state_t;
    typedef enum logic [1:0] {dam_k_none, dam_k_reg, dam_k_mem} dam_kind_t;
    typedef enum logic [2:0] {
        dam_r_sys, dam_r_ilm, dam_r_dlm, dam_r_irq, dam_r_hole
    } dam_rgn_t;
    typedef struct packed {
        dam_state_t st;
        logic busy;
        logic [2:0] cmderr;
        logic [31:0] cmd;
        logic [31:0] dataw;
        logic [31:0] addrw;
        logic [31:0] rdata;
        logic [1:0] auto_ex;
        logic ack;
        logic reg_req;
        logic mem_req;
    } dam_regs_t;
endpackage

/* logic/dam_cmd_check.sv */
// Command legality check and memory region decode
`timescale 1ns/10ps
`default_nettype none
`include "dam_map.svh"
module dam_cmd_check
    import dam_pkg::*;
#(
    parameter logic [31:0] INT_BASE = 32'hF000_0000,
    parameter logic [31:0] ILM_BASE = 32'hF000_0000,
    parameter logic [31:0] DLM_BASE = 32'hF004_0000,
    parameter logic [31:0] IRQ_BASE = 32'hF00C_0000,
    parameter int LOCAL_AW = 16
) (
    input wire logic [31:0] cmd,
    input wire logic [31:0] addr,
    input wire logic halted,
    output logic [2:0] err,
    output dam_kind_t kind
);
    if (LOCAL_AW < 8 || LOCAL_AW > 27) begin : g_aw_bad
        $error("LOCAL_AW must lie in 8..27");
    end

    // Region of an address
    function automatic dam_rgn_t rgn_of(input logic [31:0] a);
        dam_rgn_t r;
        r = dam_r_sys;
        if ((a >> LOCAL_AW) == (ILM_BASE >> LOCAL_AW)) begin
            r = dam_r_ilm;
        end else if ((a >> LOCAL_AW) == (DLM_BASE >> LOCAL_AW)) begin
            r = dam_r_dlm;
        end else if ((a >> LOCAL_AW) == (IRQ_BASE >> LOCAL_AW)) begin
            r = dam_r_irq;
        end else if (a[31:28] == INT_BASE[31:28]) begin
            r = dam_r_hole;
        end
        return r;
    endfunction

    logic [2:0] sz;
    logic narrow_bad;
    assign sz = cmd[`DAM_F_SZ +: 3];
    // Narrow sizes only reach data memory and system
    assign narrow_bad = (sz != `DAM_SZ_WORD) &&
        (rgn_of(addr) == dam_r_ilm || rgn_of(addr) == dam_r_irq);

    // Error code and kind of work for a command
    always_comb begin
        err = `DAM_E_NONE;
        kind = dam_k_none;
        if (!halted) begin
            err = `DAM_E_HALT;
        end else if (cmd[31:24] == `DAM_T_REG) begin
            if (cmd[`DAM_F_PEXEC]) begin
                err = `DAM_E_CMD;
            end else if (cmd[`DAM_F_XFER]) begin
                if (sz != `DAM_SZ_WORD) begin
                    err = `DAM_E_CMD;
                end else if (cmd[15:0] > `DAM_GPR_LAST) begin
                    err = `DAM_E_EXC;
                end else begin
                    kind = dam_k_reg;
                end
            end
        end else if (cmd[31:24] == `DAM_T_MEM) begin
            if (sz > `DAM_SZ_WORD) begin
                err = `DAM_E_CMD;
            end else if (rgn_of(addr) == dam_r_hole) begin
                err = `DAM_E_EXC;
            end else if (narrow_bad) begin
                err = `DAM_E_EXC;
            end else begin
                kind = dam_k_mem;
            end
        end else begin
            err = `DAM_E_CMD;
        end
    end
endmodule // dam_cmd_check
`default_nettype wire

/* dv/dam_core_model.sv */
// Core stand-in: register reads echoing the number and memory answering with ack pulses
`timescale 1ns/10ps
`default_nettype none
module dam_core_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] delay,
    input wire logic reg_req,
    input wire logic [15:0] reg_num,
    output logic reg_ack,
    output logic [31:0] reg_rdata,
    input wire logic mem_req,
    input wire logic mem_wr,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic mem_err,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [16];
    logic [3:0] cnt;
    // Answer after delay cycles; data lines toggle when not answering
    always @(posedge clk_sys) begin
        reg_ack <= 1'b0;
        mem_ack <= 1'b0;
        mem_err <= 1'b0;
        reg_rdata <= rst ? 32'h0000_0000 : ~reg_rdata;
        mem_rdata <= rst ? 32'h0000_0000 : ~mem_rdata;
        if (rst || reg_ack || mem_ack || !(reg_req || mem_req)) begin
            cnt <= 4'h0;
        end else if (cnt < delay) begin
            cnt <= cnt + 4'h1;
        end else if (reg_req) begin
            reg_ack <= 1'b1;
            reg_rdata <= {16'hC000, reg_num};
        end else begin
            mem_ack <= 1'b1;
            mem_err <= (mem_addr[31:28] == 4'h8);
            mem_rdata <= mem[mem_addr[5:2]];
            if (mem_wr && mem_addr[31:28] != 4'h8) begin
                mem[mem_addr[5:2]] <= mem_wdata;
            end
        end
    end
endmodule // dam_core_model
`default_nettype wire

/* dv/dam_abstract_cmd_tb.sv */
// Self-checking bench for the abstract command executor
`timescale 1ns/10ps
`default_nettype none
`include "dam_map.svh"
module dam_abstract_cmd_tb;
    logic clk_sys, rst, dmi_req, dmi_wr, halted, dmi_ack, cmd_busy;
    logic reg_req, reg_wr, reg_ack, mem_req, mem_wr, mem_ack, mem_err;
    logic mem_q, last_rwr;
    logic [6:0] dmi_addr;
    logic [31:0] dmi_wdata, dmi_rdata, reg_wdata, reg_rdata, rd;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, last_addr, last_rwd;
    logic [2:0] cmd_err;
    logic [15:0] reg_num;
    logic [1:0] mem_size, last_size;
    logic [3:0] delay;
    int fail_count, tests_run, nreq, n0;

    dam_abstract_cmd uut (.clk_sys(clk_sys), .rst(rst),
        .dmi_req(dmi_req), .dmi_wr(dmi_wr), .dmi_addr(dmi_addr),
        .dmi_wdata(dmi_wdata), .dmi_rdata(dmi_rdata), .dmi_ack(dmi_ack),
        .halted(halted), .cmd_busy(cmd_busy), .cmd_err(cmd_err),
        .reg_req(reg_req), .reg_wr(reg_wr), .reg_num(reg_num),
        .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
        .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_err(mem_err), .mem_rdata(mem_rdata));
    dam_core_model core (.clk_sys(clk_sys), .rst(rst), .delay(delay),
        .reg_req(reg_req), .reg_num(reg_num), .reg_ack(reg_ack),
        .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_err(mem_err), .mem_rdata(mem_rdata));

    // Clock at 40 ns
    always #20 clk_sys = ~clk_sys;
    // Counts memory requests, keeps the last one and the last register access
    always @(posedge clk_sys) begin
        mem_q <= mem_req;
        if (rst) begin
            nreq <= 0;
        end else if (mem_req && !mem_q) begin
            nreq <= nreq + 1;
            last_addr <= mem_addr;
            last_size <= mem_size;
        end
        if (reg_req && reg_ack) begin
            last_rwr <= reg_wr;
            last_rwd <= reg_wdata;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    // One register access, pulse request, ack one cycle later
    task automatic dmi(input logic w, input logic [6:0] a,
            input logic [31:0] d);
        @(posedge clk_sys);
        dmi_req <= 1'b1;
        dmi_wr <= w;
        dmi_addr <= a;
        dmi_wdata <= d;
        @(posedge clk_sys);
        dmi_req <= 1'b0;
        #1;
        chk("dmi_ack", 32'h1, {31'h0, dmi_ack});
        rd = dmi_rdata;
    endtask
    task automatic idle();
        int n;
        n = 0;
        while (cmd_busy !== 1'b0 && n < 60) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("busy_end", 32'h0, {31'h0, cmd_busy});
    endtask
    task automatic run(input logic [31:0] a, input logic [31:0] c);
        dmi(1'b1, `DAM_A_ADDRW, a);
        dmi(1'b1, `DAM_A_CMD, c);
        idle();
    endtask
    task automatic set_halt(input logic h);
        @(posedge clk_sys);
        halted <= h;
    endtask
    task automatic t_reset();
        dmi(1'b0, `DAM_A_AUTO, 32'h0);
        chk("auto_reset", 32'h0, rd);
        dmi(1'b0, 7'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        dmi(1'b1, `DAM_A_AUTO, 32'hFFFF_FFFF);
        dmi(1'b0, `DAM_A_AUTO, 32'h0);
        chk("auto_bits", 32'h3, rd);
        dmi(1'b1, `DAM_A_AUTO, 32'h0);
    endtask
    task automatic t_mem();
        logic [31:0] b [4] = '{32'h0000_0040, 32'hF000_0040,
            32'hF004_0040, 32'hF00C_0040};
        for (int i = 0; i < 4; i++) begin
            dmi(1'b1, `DAM_A_DATAW, 32'hA5A5_0000 + 32'(i));
            run(b[i], 32'h0221_0000);
            chk("store_addr", b[i], last_addr);
            dmi(1'b1, `DAM_A_DATAW, 32'h0);
            run(b[i], 32'h0220_0000);
            dmi(1'b0, `DAM_A_DATAW, 32'h0);
            chk("load_data", 32'hA5A5_0000 + 32'(i), rd);
        end
    endtask
    task automatic t_bump();
        for (int s = 0; s < 3; s++) begin
            run(32'hF004_0000, 32'h0208_0000 | (32'(s) << 20));
            chk("size", 32'(s), {30'h0, last_size});
            dmi(1'b0, `DAM_A_ADDRW, 32'h0);
            chk("bump", 32'hF004_0000 + (32'h1 << s), rd);
        end
        n0 = nreq;
        run(32'h0000_0010, 32'h02A6_FFFF);
        chk("loose_bits", 32'h0, {29'h0, cmd_err});
        chk("loose_run", 32'(n0 + 1), 32'(nreq));
    endtask
    task automatic t_reg();
        logic [15:0] rn [3] = '{16'h0FFF, 16'h1000, 16'h101F};
        for (int i = 0; i < 3; i++) begin
            dmi(1'b1, `DAM_A_CMD, 32'h0022_0000 | {16'h0, rn[i]});
            idle();
            dmi(1'b0, `DAM_A_DATAW, 32'h0);
            chk("reg_data", {16'hC000, rn[i]}, rd);
        end
        dmi(1'b1, `DAM_A_DATAW, 32'h5A5A_1234);
        dmi(1'b1, `DAM_A_CMD, 32'h0023_1000);
        idle();
        chk("reg_wr", 32'h1, {31'h0, last_rwr});
        chk("reg_wdata", 32'h5A5A_1234, last_rwd);
    endtask
    task automatic t_err();
        logic [31:0] c [11] = '{32'h0238_0000, 32'h0208_0000,
            32'h0218_0000, 32'h0128_0000, 32'h0022_1020, 32'h0020_1020,
            32'h0026_0000, 32'h0012_0000,
            32'h0228_0000, 32'h0228_0000, 32'h0228_0000};
        logic [31:0] a [11] = '{32'h0000_0010, 32'hF000_0000,
            32'hF00C_0000, 32'h0000_0010, 32'h0000_0010, 32'h0000_0010,
            32'h0000_0010, 32'h0000_0010,
            32'h8000_0000, 32'hF010_0000, 32'h0000_0010};
        logic [2:0] e [11] = '{3'h2, 3'h3, 3'h3, 3'h2, 3'h3, 3'h0, 3'h2,
            3'h2, 3'h5, 3'h3, 3'h4};
        for (int i = 0; i < 11; i++) begin
            set_halt(i != 10);
            run(a[i], c[i]);
            chk("err_code", 32'(e[i]), 32'(cmd_err));
            dmi(1'b0, `DAM_A_ADDRW, 32'h0);
            chk("no_bump", a[i], rd);
            dmi(1'b1, `DAM_A_CS, 32'h0000_0700);
        end
        set_halt(1'b1);
    endtask
    task automatic t_busy();
        @(posedge clk_sys);
        delay <= 4'h6;
        dmi(1'b1, `DAM_A_ADDRW, 32'h0000_0010);
        dmi(1'b1, `DAM_A_CMD, 32'h0220_0000);
        dmi(1'b0, `DAM_A_CS, 32'h0);
        chk("status_busy", 32'h0000_1002, rd);
        dmi(1'b1, `DAM_A_AUTO, 32'h1);
        idle();
        chk("busy_err", 32'h1, {29'h0, cmd_err});
        dmi(1'b0, `DAM_A_CS, 32'h0);
        chk("status_err", 32'h0000_0102, rd);
        n0 = nreq;
        dmi(1'b1, `DAM_A_CMD, 32'h0220_0000);
        idle();
        chk("cmd_ignored", 32'(n0), 32'(nreq));
        chk("err_kept", 32'h1, {29'h0, cmd_err});
        dmi(1'b0, `DAM_A_AUTO, 32'h0);
        chk("auto_kept", 32'h0, rd);
        dmi(1'b1, `DAM_A_CS, 32'h0000_0700);
        @(posedge clk_sys);
        delay <= 4'h0;
    endtask
    task automatic t_auto();
        dmi(1'b1, `DAM_A_DATAW, 32'h1234_5678);
        run(32'h0000_0020, 32'h0221_0000);
        dmi(1'b1, `DAM_A_AUTO, 32'h3);
        n0 = nreq;
        dmi(1'b0, `DAM_A_DATAW, 32'h0);
        idle();
        chk("rerun_data", 32'(n0 + 1), 32'(nreq));
        dmi(1'b1, `DAM_A_ADDRW, 32'h0000_0024);
        idle();
        chk("rerun_addr", 32'(n0 + 2), 32'(nreq));
        chk("rerun_new", 32'h0000_0024, last_addr);
        set_halt(1'b0);
        dmi(1'b0, `DAM_A_DATAW, 32'h0);
        idle();
        chk("halt_err", 32'h4, {29'h0, cmd_err});
        dmi(1'b0, `DAM_A_ADDRW, 32'h0);
        idle();
        chk("no_rerun", 32'(n0 + 2), 32'(nreq));
        dmi(1'b1, `DAM_A_CS, 32'h0000_0700);
        dmi(1'b1, `DAM_A_AUTO, 32'h0);
        set_halt(1'b1);
    endtask
    task automatic t_rst2();
        run(32'h0000_0010, 32'h0200_0000);
        chk("size_byte", 32'h0, {30'h0, mem_size});
        dmi(1'b1, `DAM_A_AUTO, 32'h3);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("size_reset", 32'h2, {30'h0, mem_size});
        chk("err_reset", 32'h0, {29'h0, cmd_err});
        dmi(1'b0, `DAM_A_AUTO, 32'h0);
        chk("auto_reset2", 32'h0, rd);
    endtask
    task automatic end_of_test();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {dmi_req, dmi_wr} = 2'h0;
        dmi_addr = 7'h0;
        dmi_wdata = 32'h0;
        halted = 1'b1;
        delay = 4'h0;
        {fail_count, tests_run} = {32'h0, 32'h0};
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_mem();
        t_bump();
        t_reg();
        t_err();
        t_busy();
        t_auto();
        t_rst2();
        end_of_test();
    end
    // Watchdog
    initial begin
        #400_000;
        fail_count++;
        end_of_test();
    end
endmodule // dam_abstract_cmd_tb
`default_nettype wire
